// >>> common/asfr_regs.vh
`ifndef ASFR_REGS_VH
`define ASFR_REGS_VH

// apb byte offsets
`define ASFR_STATUS_OFS 12'h000
`define ASFR_RESULT_OFS 12'h004

// flag positions inside the status register
`define ASFR_C_BIT 0
`define ASFR_DC_BIT 1
`define ASFR_Z_BIT 2
`define ASFR_OV_BIT 3
`define ASFR_N_BIT 4
`define ASFR_FLAG_W 5

// reset values
`define ASFR_STATUS_RST 5'h00
`define ASFR_RESULT_RST 8'h00

// flag update masks, ordered {negative, overflow, zero, digit, carry}
`define ASFR_MASK_ALL 5'h1F
`define ASFR_MASK_NZ 5'h14
`define ASFR_MASK_NZC 5'h15
`define ASFR_MASK_Z 5'h04
`define ASFR_MASK_NONE 5'h00

// operation codes
`define ASFR_OP_ADD 5'h00
`define ASFR_OP_ADDC 5'h01
`define ASFR_OP_SUB 5'h02
`define ASFR_OP_SUBB 5'h03
`define ASFR_OP_INC 5'h04
`define ASFR_OP_DEC 5'h05
`define ASFR_OP_NEG 5'h06
`define ASFR_OP_AND 5'h07
`define ASFR_OP_IOR 5'h08
`define ASFR_OP_XOR 5'h09
`define ASFR_OP_COM 5'h0A
`define ASFR_OP_MOVF 5'h0B
`define ASFR_OP_RLC 5'h0C
`define ASFR_OP_RRC 5'h0D
`define ASFR_OP_RLN 5'h0E
`define ASFR_OP_RRN 5'h0F
`define ASFR_OP_CLR 5'h10
`define ASFR_OP_SETF 5'h11
`define ASFR_OP_BCLR 5'h12
`define ASFR_OP_BSET 5'h13
`define ASFR_OP_SWAP 5'h14
`define ASFR_OP_FILE_TO_FILE_MOVE_INSTR 5'h15
`define ASFR_OP_WORKING_TO_FILE_MOVE_INSTR 5'h16

`endif

// >>> core/asfr_alu.v
`timescale 1ns/100ps
`include "asfr_regs.vh"

module asfr_alu (
  input wire [4:0] op_i,
  input wire [7:0] wreg_i,
  input wire [7:0] file_i,
  input wire [2:0] bit_sel_i,
  input wire carry_i,
  output reg [7:0] res_o,
  output reg [4:0] flg_o
);

  reg [7:0] x;
  reg [7:0] y;
  reg cin;
  reg [8:0] sum;
  reg [4:0] half;
  reg rot_c;
  reg [7:0] onehot;

  always @* begin
    x = file_i;
    y = 8'h00;
    cin = 1'b0;
    rot_c = carry_i;
    onehot = 8'h01 << bit_sel_i;
    case (op_i)
      `ASFR_OP_ADD: y = wreg_i;
      `ASFR_OP_ADDC: begin
        y = wreg_i;
        cin = carry_i;
      end
      // subtract as add of complement: carry out is the inverted borrow
      `ASFR_OP_SUB: begin
        y = ~wreg_i;
        cin = 1'b1;
      end
      `ASFR_OP_SUBB: begin
        y = ~wreg_i;
        cin = carry_i;
      end
      `ASFR_OP_INC: cin = 1'b1;
      `ASFR_OP_DEC: y = 8'hFF;
      `ASFR_OP_NEG: begin
        x = 8'h00;
        y = ~file_i;
        cin = 1'b1;
      end
      default: y = 8'h00;
    endcase
    sum = {1'b0, x} + {1'b0, y} + {8'h00, cin};
    half = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
    case (op_i)
      `ASFR_OP_AND: res_o = wreg_i & file_i;
      `ASFR_OP_IOR: res_o = wreg_i | file_i;
      `ASFR_OP_XOR: res_o = wreg_i ^ file_i;
      `ASFR_OP_COM: res_o = ~file_i;
      `ASFR_OP_MOVF: res_o = file_i;
      `ASFR_OP_RLC: begin
        res_o = {file_i[6:0], carry_i};
        rot_c = file_i[7];
      end
      `ASFR_OP_RRC: begin
        res_o = {carry_i, file_i[7:1]};
        rot_c = file_i[0];
      end
      `ASFR_OP_RLN: res_o = {file_i[6:0], file_i[7]};
      `ASFR_OP_RRN: res_o = {file_i[0], file_i[7:1]};
      `ASFR_OP_CLR: res_o = 8'h00;
      `ASFR_OP_SETF: res_o = 8'hFF;
      `ASFR_OP_BCLR: res_o = file_i & ~onehot;
      `ASFR_OP_BSET: res_o = file_i | onehot;
      `ASFR_OP_SWAP: res_o = {file_i[3:0], file_i[7:4]};
      `ASFR_OP_FILE_TO_FILE_MOVE_INSTR: res_o = file_i;
      `ASFR_OP_WORKING_TO_FILE_MOVE_INSTR: res_o = wreg_i;
      default: res_o = sum[7:0];
    endcase
    flg_o[`ASFR_N_BIT] = res_o[7];
    flg_o[`ASFR_OV_BIT] = (x[7] == y[7]) && (sum[7] != x[7]);
    flg_o[`ASFR_Z_BIT] = (res_o == 8'h00);
    flg_o[`ASFR_DC_BIT] = half[4];
    flg_o[`ASFR_C_BIT] = ((op_i == `ASFR_OP_RLC) ||
                          (op_i == `ASFR_OP_RRC)) ? rot_c : sum[8];
  end

endmodule

// >>> core/asfr_status.v
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "asfr_regs.vh"

// Function
// - the five condition flags live in one register that always holds the outcome of the last flag-changing operation; a write to it overrides that.
// - the flag register can be read as a source and written as a destination of any instruction, like any other register.
// - an instruction that changes flags and names the flag register as destination drops its result and only updates the flags.
// - clearing the flag register sets the zero flag, keeps the other four, and the top three bits read zero.
// - bit clear, bit set, nibble swap and both moves write the flag register without touching any flag.
// - in subtraction carry and digit carry are the inverted borrow and inverted digit borrow.
module asfr_status (
  input wire core_clk_i,
  input wire arst_n_i,
  input wire exec_valid_i,
  input wire [4:0] exec_op_i,
  input wire [7:0] exec_w_i,
  input wire [7:0] exec_f_i,
  input wire [2:0] exec_bit_i,
  input wire exec_src_status_i,
  input wire exec_dst_status_i,
  output wire [7:0] result_o,
  output wire result_valid_o,
  output wire result_discard_o,
  output wire [7:0] status_o,
  input wire [11:0] paddr_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o
);

  reg [4:0] status_q;
  reg [4:0] status_d;
  reg [7:0] result_q;
  reg [7:0] result_d;
  reg result_valid_q;
  reg result_valid_d;
  reg result_discard_q;
  reg result_discard_d;
  reg [7:0] status_rd_q;
  reg [31:0] prdata_q;
  reg pready_q;
  reg pslverr_q;

  wire [7:0] status_view;
  wire [7:0] src_f;
  wire [7:0] alu_res;
  wire [4:0] alu_flg;
  wire [4:0] upd_mask;
  wire [4:0] merged;
  wire apb_access;
  wire apb_first;
  wire apb_commit;
  wire hit_status;
  wire hit_result;
  wire apb_wr_status;

  function [4:0] flag_mask;
    input [4:0] op;
    begin
      case (op)
        `ASFR_OP_ADD, `ASFR_OP_ADDC, `ASFR_OP_SUB, `ASFR_OP_SUBB,
        `ASFR_OP_INC, `ASFR_OP_DEC, `ASFR_OP_NEG:
          flag_mask = `ASFR_MASK_ALL;
        `ASFR_OP_AND, `ASFR_OP_IOR, `ASFR_OP_XOR, `ASFR_OP_COM,
        `ASFR_OP_MOVF, `ASFR_OP_RLN, `ASFR_OP_RRN:
          flag_mask = `ASFR_MASK_NZ;
        `ASFR_OP_RLC, `ASFR_OP_RRC:
          flag_mask = `ASFR_MASK_NZC;
        `ASFR_OP_CLR:
          flag_mask = `ASFR_MASK_Z;
        // bit ops, swap and moves leave every flag alone
        default:
          flag_mask = `ASFR_MASK_NONE;
      endcase
    end
  endfunction

  assign status_view = {3'b000, status_q};
  // flag register as a source operand reads like any other file register
  assign src_f = exec_src_status_i ? status_view : exec_f_i;

  asfr_alu asfr_alu_inst (
    .op_i(exec_op_i),
    .wreg_i(exec_w_i),
    .file_i(src_f),
    .bit_sel_i(exec_bit_i),
    .carry_i(status_q[`ASFR_C_BIT]),
    .res_o(alu_res),
    .flg_o(alu_flg)
  );

  assign upd_mask = flag_mask(exec_op_i);
  assign merged = (status_q & ~upd_mask) | (alu_flg & upd_mask);

  // apb: one wait state, pready comes from a flop
  assign apb_access = psel_i & penable_i;
  assign apb_first = apb_access & ~pready_q;
  assign apb_commit = apb_access & pready_q;
  assign hit_status = (paddr_i == `ASFR_STATUS_OFS);
  assign hit_result = (paddr_i == `ASFR_RESULT_OFS);
  assign apb_wr_status = apb_commit & pwrite_i & hit_status & pstrb_i[0];

  always @* begin
    status_d = status_q;
    result_d = result_q;
    result_valid_d = 1'b0;
    result_discard_d = 1'b0;
    if (exec_valid_i) begin
      if (exec_dst_status_i && (upd_mask != `ASFR_MASK_NONE)) begin
        // the computed byte is thrown away, only flags change
        status_d = merged;
        result_discard_d = 1'b1;
      end else if (exec_dst_status_i) begin
        // plain write of the result, upper bits do not exist
        status_d = alu_res[4:0];
        result_d = alu_res;
        result_valid_d = 1'b1;
      end else begin
        status_d = merged;
        result_d = alu_res;
        result_valid_d = 1'b1;
      end
    end else if (apb_wr_status) begin
      // core execution has priority; a clashing bus write is dropped
      status_d = pwdata_i[4:0];
    end
  end

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_q <= `ASFR_STATUS_RST;
      result_q <= `ASFR_RESULT_RST;
      result_valid_q <= 1'b0;
      result_discard_q <= 1'b0;
      status_rd_q <= 8'h00;
    end else begin
      status_q <= status_d;
      result_q <= result_d;
      result_valid_q <= result_valid_d;
      result_discard_q <= result_discard_d;
      status_rd_q <= {3'b000, status_d};
    end
  end

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= apb_first;
      pslverr_q <= apb_first & ~(hit_status | hit_result);
      if (apb_first && !pwrite_i && hit_status) begin
        prdata_q <= {27'h0, status_q};
      end else if (apb_first && !pwrite_i && hit_result) begin
        prdata_q <= {24'h000000, result_q};
      end else if (apb_first) begin
        prdata_q <= 32'h00000000;
      end
    end
  end

  assign result_o = result_q;
  assign result_valid_o = result_valid_q;
  assign result_discard_o = result_discard_q;
  assign status_o = status_rd_q;
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

endmodule

// >>> verif/asfr_status_sva.sv
`timescale 1ns/100ps
`include "asfr_regs.vh"
module asfr_status_sva (
  input wire core_clk_i,
  input wire arst_n_i,
  input wire exec_valid_i,
  input wire [4:0] exec_op_i,
  input wire [7:0] exec_w_i,
  input wire [7:0] exec_f_i,
  input wire exec_src_status_i,
  input wire exec_dst_status_i,
  input wire [7:0] result_o,
  input wire result_valid_o,
  input wire result_discard_o,
  input wire [7:0] status_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  wire ex = exec_valid_i & ~exec_dst_status_i & ~exec_src_status_i;
  wire tgt = exec_valid_i & exec_dst_status_i;
  a_upper_zero: assert property (status_o[7:5] == 3'h0)
    else $error("status upper bits not zero");
  a_result_kept: assert property (ex |=> result_valid_o && !result_discard_o)
    else $error("result not kept");
  a_discard_hold: assert property (result_discard_o |-> $stable(result_o))
    else $error("discarded result reached result_o");
  a_clear_zero: assert property (tgt && exec_op_i == `ASFR_OP_CLR |=>
    result_discard_o && status_o == ($past(status_o) | 8'h04))
    else $error("clear of flags wrong");
  a_move_flags: assert property (tgt && exec_op_i == `ASFR_OP_WORKING_TO_FILE_MOVE_INSTR |=>
    result_valid_o && status_o[4:0] == $past(exec_w_i[4:0]))
    else $error("move into flags wrong");
  a_bitop_keep: assert property (ex && exec_op_i >= `ASFR_OP_BCLR &&
    exec_op_i <= `ASFR_OP_WORKING_TO_FILE_MOVE_INSTR |=> $stable(status_o))
    else $error("flags changed by non-flag op");
  a_sub_carry: assert property (ex && exec_op_i == `ASFR_OP_SUB |=>
    status_o[0] == ($past(exec_f_i) >= $past(exec_w_i)) &&
    status_o[1] == ($past(exec_f_i[3:0]) >= $past(exec_w_i[3:0])))
    else $error("borrow flags wrong");
  a_zero_and: assert property (ex && exec_op_i == `ASFR_OP_AND |=>
    status_o[2] == (result_o == 8'h00))
    else $error("zero flag wrong");
  a_src_read: assert property (exec_valid_i && exec_src_status_i &&
    !exec_dst_status_i && exec_op_i == `ASFR_OP_MOVF |=>
    result_o == $past(status_o))
    else $error("flags as source wrong");
endmodule

// >>> verif/asfr_status_tb.sv
`timescale 1ns/100ps
`include "asfr_regs.vh"
module asfr_status_tb;
  reg core_clk_i = 0, arst_n_i = 0, exec_valid_i = 0;
  reg exec_src_status_i = 0, exec_dst_status_i = 0;
  reg [4:0] exec_op_i = 0;
  reg [7:0] exec_w_i = 0, exec_f_i = 0;
  reg [2:0] exec_bit_i = 0;
  reg psel_i = 0, penable_i = 0, pwrite_i = 0;
  reg [11:0] paddr_i = 0;
  reg [31:0] pwdata_i = 0;
  reg [3:0] pstrb_i = 0;
  wire [7:0] result_o, status_o;
  wire result_valid_o, result_discard_o, pready_o, pslverr_o;
  wire [31:0] prdata_o;
  reg [4:0] flg = 0;
  reg [7:0] res = 0;
  reg [13:0] em;
  reg [13:0] pm;
  reg [31:0] r;
  reg [13:0] eq[$];
  reg [32:0] rq[$];
  reg [4:0] ops[0:7] = '{`ASFR_OP_ADD, `ASFR_OP_SUB, `ASFR_OP_AND,
    `ASFR_OP_MOVF, `ASFR_OP_CLR, `ASFR_OP_BSET, `ASFR_OP_SWAP, `ASFR_OP_WORKING_TO_FILE_MOVE_INSTR};
  integer err_total = 0, checks = 0, seed = 32'h0db3, i;
  always #50 core_clk_i = ~core_clk_i;
  asfr_status asfr_status_inst (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .exec_valid_i(exec_valid_i),
    .exec_op_i(exec_op_i),
    .exec_w_i(exec_w_i),
    .exec_f_i(exec_f_i),
    .exec_bit_i(exec_bit_i),
    .exec_src_status_i(exec_src_status_i),
    .exec_dst_status_i(exec_dst_status_i),
    .result_o(result_o),
    .result_valid_o(result_valid_o),
    .result_discard_o(result_discard_o),
    .status_o(status_o),
    .paddr_i(paddr_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o)
  );
  task stop_test;
    begin
      if (err_total == 0 && checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [32:0] g, input [32:0] e, input [63:0] n);
    begin
      checks = checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  // returns {discard, flags, result}
  function [13:0] mdl(input [4:0] o, input [7:0] a, input [7:0] b,
    input [2:0] k, input d);
    reg [8:0] s;
    reg [4:0] h, m, nf;
    reg v;
    begin
      m = 5'h14;
      h = 0;
      v = 0;
      s = b;
      case (o)
        `ASFR_OP_ADD: begin
          s = a + b;
          h = a[3:0] + b[3:0];
          m = 5'h1F;
          v = a[7] == b[7] && s[7] != b[7];
        end
        `ASFR_OP_SUB: begin
          s = b + {1'b0, ~a} + 1;
          h = b[3:0] + {1'b0, ~a[3:0]} + 1;
          m = 5'h1F;
          v = a[7] != b[7] && s[7] != b[7];
        end
        `ASFR_OP_AND: s = a & b;
        `ASFR_OP_MOVF: s = b;
        `ASFR_OP_CLR: begin
          s = 0;
          m = 5'h04;
        end
        `ASFR_OP_BCLR: m = 0;
        `ASFR_OP_BSET: begin
          s = b | (8'h01 << k);
          m = 0;
        end
        `ASFR_OP_SWAP: begin
          s = {b[3:0], b[7:4]};
          m = 0;
        end
        `ASFR_OP_FILE_TO_FILE_MOVE_INSTR: m = 0;
        default: begin
          s = a;
          m = 0;
        end
      endcase
      if (o == `ASFR_OP_BCLR)
        s = b & ~(8'h01 << k);
      nf = flg & ~m | {s[7], v, s[7:0] == 0, h[4], s[8]} & m;
      if (d && m == 0)
        nf = s[4:0];
      mdl = {d && m != 0, nf, d && m != 0 ? res : s[7:0]};
    end
  endfunction
  task ex(input [4:0] o, input [7:0] a, input [7:0] b, input [2:0] k,
    input sr, input d);
    begin
      em = mdl(o, a, sr ? {3'h0, flg} : b, k, d);
      {flg, res} = em[12:0];
      eq.push_back(em);
      exec_valid_i <= 1;
      exec_op_i <= o;
      exec_w_i <= a;
      exec_f_i <= b;
      exec_bit_i <= k;
      exec_src_status_i <= sr;
      exec_dst_status_i <= d;
      @(posedge core_clk_i);
    end
  endtask
  task apb(input wr, input [11:0] a, input [31:0] d, input [3:0] st,
    input [32:0] e);
    begin
      if (!wr)
        rq.push_back(e);
      exec_valid_i <= 0;
      psel_i <= 1;
      paddr_i <= a;
      pwrite_i <= wr;
      pwdata_i <= d;
      pstrb_i <= st;
      @(posedge core_clk_i);
      penable_i <= 1;
      // look at pready away from the edge that launches it
      @(negedge core_clk_i);
      while (pready_o !== 1'b1)
        @(negedge core_clk_i);
      @(posedge core_clk_i);
      psel_i <= 0;
      penable_i <= 0;
      if (wr && a == `ASFR_STATUS_OFS && st[0])
        flg = d[4:0];
      @(posedge core_clk_i);
    end
  endtask
  always @(negedge core_clk_i) begin
    if (result_valid_o | result_discard_o) begin
      pm = eq.pop_front();
      chk({result_discard_o, status_o, result_o}, {pm[13], 3'h0, pm[12:0]},
        "exec");
    end
    if (psel_i & penable_i & pready_o & !pwrite_i)
      chk({pslverr_o, prdata_o}, rq.pop_front(), "apb");
  end
  initial begin
    #200000;
    err_total = err_total + 1;
    stop_test;
  end
  initial begin
    repeat (5) @(posedge core_clk_i);
    arst_n_i <= 1;
    apb(0, `ASFR_STATUS_OFS, 0, 0, 0);
    apb(0, `ASFR_RESULT_OFS, 0, 0, 0);
    ex(`ASFR_OP_SUB, 8'h03, 8'h05, 0, 0, 0);
    for (i = 0; i < 64; i = i + 1) begin
      r = $random(seed);
      ex(ops[r[2:0]], r[15:8], r[23:16], r[26:24], r[27], r[28]);
    end
    apb(1, `ASFR_STATUS_OFS, 32'h1B, 4'h1, 0);
    apb(1, `ASFR_STATUS_OFS, 32'h00, 4'h0, 0);
    apb(1, `ASFR_RESULT_OFS, 32'h55, 4'hF, 0);
    ex(`ASFR_OP_CLR, 8'h00, 8'h00, 0, 0, 1);
    ex(`ASFR_OP_ADD, 8'h80, 8'h80, 0, 0, 1);
    // both destinations for the bit ops, swap and both moves (SETF is not driven)
    for (i = 0; i < 10; i = i + 1)
      ex(`ASFR_OP_BCLR + i[3:1], $random(seed), $random(seed), i[2:0],
        i[1], i[0]);
    apb(0, `ASFR_STATUS_OFS, 0, 0, {28'h0, flg});
    apb(0, `ASFR_RESULT_OFS, 0, 0, {25'h0, res});
    apb(0, 12'h008, 0, 0, {1'b1, 32'h0});
    arst_n_i <= 0;
    repeat (2) @(posedge core_clk_i);
    arst_n_i <= 1;
    flg = 0;
    res = 0;
    apb(0, `ASFR_STATUS_OFS, 0, 0, 0);
    ex(`ASFR_OP_ADD, 8'h7F, 8'h01, 0, 0, 0);
    exec_valid_i <= 0;
    repeat (2) @(posedge core_clk_i);
    chk(eq.size() + rq.size(), 0, "queue");
    stop_test;
  end
endmodule
bind asfr_status asfr_status_sva asfr_status_sva_inst (
  .core_clk_i(core_clk_i),
  .arst_n_i(arst_n_i),
  .exec_valid_i(exec_valid_i),
  .exec_op_i(exec_op_i),
  .exec_w_i(exec_w_i),
  .exec_f_i(exec_f_i),
  .exec_src_status_i(exec_src_status_i),
  .exec_dst_status_i(exec_dst_status_i),
  .result_o(result_o),
  .result_valid_o(result_valid_o),
  .result_discard_o(result_discard_o),
  .status_o(status_o)
);
